/* avs_pkg.sv */
// Constants and types for the switch configuration register bank
// Function
// - Path enable 0 means standby, 1 active
// - Source select 00 A, 01 B, 10 C
// - Sideband enable 0 disconnects all sideband lines
// - Sideband select 00 A, 01 B, 10 C
// - Input termination select gates all input terminations
// - Pulse bit drops termination 100 ms on switch
// - Pulse bits: B0-B3, A0-A3, then C3-C0
// - Equalizer bit low 6 dB, high 12 dB
// - Equalizer bits map like the pulse bits
// - Pre-emphasis 0, 2, 4, 6 dB, all channels
// - Output termination select switches all outputs
// - Serial access overrides straps until next reset
package avs_pkg;
  // Timing
  localparam int CLK_KHZ = 20000;
  localparam int TERM_PULSE_MS = 100;
  localparam int TERM_PULSE_CYC = TERM_PULSE_MS * CLK_KHZ;
  localparam int PULSE_CNT_W = 21;
  // Register offsets
  localparam logic [7:0] OFS_PATH = 8'h00;
  localparam logic [7:0] OFS_SIDEBAND = 8'h01;
  localparam logic [7:0] OFS_IN_TERM = 8'h10;
  localparam logic [7:0] OFS_PULSE_LO = 8'h11;
  localparam logic [7:0] OFS_PULSE_HI = 8'h12;
  localparam logic [7:0] OFS_EQ_LO = 8'h13;
  localparam logic [7:0] OFS_EQ_HI = 8'h14;
  localparam logic [7:0] OFS_OUT_DRIVE = 8'h20;
  // Reset values
  localparam logic [7:0] RST_PATH = 8'h40;
  localparam logic [7:0] RST_SIDEBAND = 8'h40;
  localparam logic [7:0] RST_IN_TERM = 8'h01;
  localparam logic [7:0] RST_PULSE = 8'h00;
  localparam logic [7:0] RST_EQ = 8'h00;
  localparam logic [7:0] RST_OUT_DRIVE = 8'h03;
  // Writable bits; the rest read as zero
  localparam logic [7:0] MASK_PATH = 8'h43;
  localparam logic [7:0] MASK_IN_TERM = 8'h01;
  localparam logic [7:0] MASK_LO = 8'hFF;
  localparam logic [7:0] MASK_HI = 8'h0F;
  localparam logic [7:0] MASK_OUT_DRIVE = 8'h0F;
  // Field positions
  localparam int EN_BIT = 6;
  localparam int SEL_LSB = 0;
  localparam int TERM_BIT = 0;
  localparam int PTO_BIT = 1;
  localparam int PE_LSB = 2;
  localparam logic [1:0] SEL_ILLEGAL = 2'h3;
  // Serial port: upper address bits, arbitrary value
  localparam logic [5:0] DEV_ADDR_HI = 6'h2A;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD
  } avs_state_t;
endpackage

/* avs_config_regs.sv */
// Serial-programmed configuration bank of the 3:1 video link switch
`timescale 1ns/1ps
module avs_config_regs #(
  parameter int PULSE_CYC = avs_pkg::TERM_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial control port, open-drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_lsb_pin,
  // Pin straps used until the first serial access
  input wire logic strap_fast_on,
  input wire logic [1:0] strap_source,
  input wire logic strap_eq_high,
  input wire logic [1:0] strap_preemph,
  // Switch controls
  output logic serial_mode,
  output logic fast_path_on,
  output logic [1:0] fast_source_select,
  output logic sideband_on,
  output logic [1:0] sideband_source_select,
  output logic [3:0] input_term_on_a,
  output logic [3:0] input_term_on_b,
  output logic [3:0] input_term_on_c,
  output logic [3:0] input_eq_high_a,
  output logic [3:0] input_eq_high_b,
  output logic [3:0] input_eq_high_c,
  output logic [1:0] output_preemph_level,
  output logic output_term_on
);
  // Pin synchronisers: scl, sda, addr, on, src[2], eq, pe[2]
  localparam int NP = 9;
  logic [NP-1:0] pin_raw, s1_r, s2_r, s3_r, pin_f_r;
  assign pin_raw = {strap_preemph, strap_eq_high, strap_source,
                    strap_fast_on, addr_lsb_pin, sda_in, scl_in};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Idle-high like the filter, so no false edge follows reset
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pin
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pin_f_r[gp] <= 1'b1;
        end else if (s2_r[gp] == s3_r[gp]) begin
          pin_f_r[gp] <= s3_r[gp];
        end
      end
    end
  endgenerate

  logic scl_q_r, sda_q_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= pin_f_r[0];
      sda_q_r <= pin_f_r[1];
    end
  end
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl = pin_f_r[0];
  assign sda = pin_f_r[1];
  assign scl_rise = scl & ~scl_q_r;
  assign scl_fall = ~scl & scl_q_r;
  assign start_c = scl & scl_q_r & sda_q_r & ~sda;
  assign stop_c = scl & scl_q_r & ~sda_q_r & sda;

  // Configuration registers
  logic [7:0] path_r, side_r, in_term_r, pls_lo_r, pls_hi_r;
  logic [7:0] eq_lo_r, eq_hi_r, drv_r;
  logic wr_stb_r;
  logic [7:0] wr_addr_r, wr_data_r;

  function automatic logic [7:0] rd_data(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == avs_pkg::OFS_PATH) begin
      d = path_r;
    end else if (a == avs_pkg::OFS_SIDEBAND) begin
      d = side_r;
    end else if (a == avs_pkg::OFS_IN_TERM) begin
      d = in_term_r;
    end else if (a == avs_pkg::OFS_PULSE_LO) begin
      d = pls_lo_r;
    end else if (a == avs_pkg::OFS_PULSE_HI) begin
      d = pls_hi_r;
    end else if (a == avs_pkg::OFS_EQ_LO) begin
      d = eq_lo_r;
    end else if (a == avs_pkg::OFS_EQ_HI) begin
      d = eq_hi_r;
    end else if (a == avs_pkg::OFS_OUT_DRIVE) begin
      d = drv_r;
    end
    return d;
  endfunction

  // Read byte at the current pointer
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = rd_data(ptr_r);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      path_r <= avs_pkg::RST_PATH;
      side_r <= avs_pkg::RST_SIDEBAND;
      in_term_r <= avs_pkg::RST_IN_TERM;
      pls_lo_r <= avs_pkg::RST_PULSE;
      pls_hi_r <= avs_pkg::RST_PULSE;
      eq_lo_r <= avs_pkg::RST_EQ;
      eq_hi_r <= avs_pkg::RST_EQ;
      drv_r <= avs_pkg::RST_OUT_DRIVE;
    end else if (wr_stb_r) begin
      if (wr_addr_r == avs_pkg::OFS_PATH) begin
        path_r <= wr_data_r & avs_pkg::MASK_PATH;
      end else if (wr_addr_r == avs_pkg::OFS_SIDEBAND) begin
        side_r <= wr_data_r & avs_pkg::MASK_PATH;
      end else if (wr_addr_r == avs_pkg::OFS_IN_TERM) begin
        in_term_r <= wr_data_r & avs_pkg::MASK_IN_TERM;
      end else if (wr_addr_r == avs_pkg::OFS_PULSE_LO) begin
        pls_lo_r <= wr_data_r & avs_pkg::MASK_LO;
      end else if (wr_addr_r == avs_pkg::OFS_PULSE_HI) begin
        pls_hi_r <= wr_data_r & avs_pkg::MASK_HI;
      end else if (wr_addr_r == avs_pkg::OFS_EQ_LO) begin
        eq_lo_r <= wr_data_r & avs_pkg::MASK_LO;
      end else if (wr_addr_r == avs_pkg::OFS_EQ_HI) begin
        eq_hi_r <= wr_data_r & avs_pkg::MASK_HI;
      end else if (wr_addr_r == avs_pkg::OFS_OUT_DRIVE) begin
        drv_r <= wr_data_r & avs_pkg::MASK_OUT_DRIVE;
      end
    end
  end

  // Serial slave: bit_cnt 0-7 data bits, 8 byte done, 9 acknowledge
  avs_pkg::avs_state_t st_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, ptr_r;
  logic rw_r, match;
  assign match = shift_r[7:1] == {avs_pkg::DEV_ADDR_HI, pin_f_r[2]};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= avs_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      serial_mode <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      sda_out <= 1'b0;
      if (stop_c) begin
        st_r <= avs_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_c) begin
        st_r <= avs_pkg::ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe <= 1'b0;
      end else if (st_r == avs_pkg::ST_RD) begin
        if (scl_rise && bit_cnt_r < 4'h8) begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (scl_rise && bit_cnt_r == 4'h8) begin
          if (sda) begin
            st_r <= avs_pkg::ST_IDLE;
          end else begin
            bit_cnt_r <= 4'h9;
          end
        end else if (scl_fall && bit_cnt_r == 4'h8) begin
          sda_oe <= 1'b0;
        end else if (scl_fall && bit_cnt_r == 4'h9) begin
          shift_r <= rd_byte;
          sda_oe <= ~rd_byte[7];
          ptr_r <= ptr_r + 8'h01;
          bit_cnt_r <= 4'h0;
        end else if (scl_fall && bit_cnt_r != 4'h0) begin
          shift_r <= {shift_r[6:0], 1'b0};
          sda_oe <= ~shift_r[6];
        end
      end else if (st_r != avs_pkg::ST_IDLE) begin
        if (scl_rise && bit_cnt_r < 4'h8) begin
          shift_r <= {shift_r[6:0], sda};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (scl_fall && bit_cnt_r == 4'h8) begin
          bit_cnt_r <= 4'h9;
          sda_oe <= 1'b1;
          case (st_r)
            avs_pkg::ST_ADDR: begin
              if (match) begin
                rw_r <= shift_r[0];
                serial_mode <= 1'b1;
              end else begin
                st_r <= avs_pkg::ST_IDLE;
                sda_oe <= 1'b0;
              end
            end
            avs_pkg::ST_PTR: begin
              ptr_r <= shift_r;
            end
            default: begin
              wr_stb_r <= 1'b1;
              wr_addr_r <= ptr_r;
              wr_data_r <= shift_r;
              ptr_r <= ptr_r + 8'h01;
            end
          endcase
        end else if (scl_fall && bit_cnt_r == 4'h9) begin
          bit_cnt_r <= 4'h0;
          sda_oe <= 1'b0;
          if (st_r == avs_pkg::ST_ADDR && rw_r) begin
            st_r <= avs_pkg::ST_RD;
            shift_r <= rd_byte;
            sda_oe <= ~rd_byte[7];
            ptr_r <= ptr_r + 8'h01;
          end else if (st_r == avs_pkg::ST_ADDR) begin
            st_r <= avs_pkg::ST_PTR;
          end else begin
            st_r <= avs_pkg::ST_WR;
          end
        end
      end
    end
  end

  // Effective settings: registers once serial; before that, straps, or fixed defaults where no strap exists
  logic cand_on, cand_sb_on, cand_term, sel_chg, pulse_act;
  logic [1:0] cand_sel, cand_sb_sel, cand_pe;
  logic [11:0] cand_pulse, cand_eq;
  logic [avs_pkg::PULSE_CNT_W-1:0] pulse_cnt_r;
  always_comb begin
    cand_on = serial_mode ? path_r[avs_pkg::EN_BIT] : pin_f_r[3];
    cand_sel = serial_mode ? path_r[avs_pkg::SEL_LSB +: 2] : pin_f_r[5:4];
    cand_sb_on = serial_mode ? side_r[avs_pkg::EN_BIT] : 1'b1;
    cand_sb_sel = serial_mode ? side_r[avs_pkg::SEL_LSB +: 2]
                              : pin_f_r[5:4];
    cand_term = serial_mode ? in_term_r[avs_pkg::TERM_BIT] : 1'b1;
    cand_pulse = serial_mode ? {pls_hi_r[3:0], pls_lo_r} : 12'h000;
    cand_eq = serial_mode ? {eq_hi_r[3:0], eq_lo_r} : {12{pin_f_r[6]}};
    cand_pe = serial_mode ? drv_r[avs_pkg::PE_LSB +: 2] : pin_f_r[8:7];
  end
  // an illegal code never reaches the routing
  assign sel_chg = cand_sel != avs_pkg::SEL_ILLEGAL &&
                   cand_sel != fast_source_select;
  assign pulse_act = pulse_cnt_r != '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fast_path_on <= 1'b0;
      fast_source_select <= 2'h0;
      sideband_on <= 1'b0;
      sideband_source_select <= 2'h0;
      output_preemph_level <= 2'h0;
      output_term_on <= 1'b0;
    end else begin
      fast_path_on <= cand_on;
      // source routing, holds on illegal code
      if (sel_chg) begin
        fast_source_select <= cand_sel;
      end
      sideband_on <= cand_sb_on;
      // sideband routing, holds on illegal code
      if (cand_sb_sel != avs_pkg::SEL_ILLEGAL) begin
        sideband_source_select <= cand_sb_sel;
      end
      // one pre-emphasis level for all outputs
      output_preemph_level <= cand_pe;
      output_term_on <= serial_mode ? drv_r[avs_pkg::PTO_BIT] : 1'b1;
    end
  end

  // termination gap timer started by a source change
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulse_cnt_r <= '0;
    end else if (sel_chg) begin
      pulse_cnt_r <= avs_pkg::PULSE_CNT_W'(PULSE_CYC);
    end else if (pulse_act) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < 4; gc++) begin : g_chan
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          input_term_on_a[gc] <= 1'b0;
          input_term_on_b[gc] <= 1'b0;
          input_term_on_c[gc] <= 1'b0;
          input_eq_high_a[gc] <= 1'b0;
          input_eq_high_b[gc] <= 1'b0;
          input_eq_high_c[gc] <= 1'b0;
        end else begin
          input_term_on_b[gc] <= cand_term & ~(pulse_act & cand_pulse[gc]);
          input_term_on_a[gc] <= cand_term &
                                 ~(pulse_act & cand_pulse[4+gc]);
          input_term_on_c[gc] <= cand_term &
                                 ~(pulse_act & cand_pulse[11-gc]);
          // 0 low, 1 high; same map as pulse bits
          input_eq_high_b[gc] <= cand_eq[gc];
          input_eq_high_a[gc] <= cand_eq[4+gc];
          input_eq_high_c[gc] <= cand_eq[11-gc];
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_path_standby: assert property (
    serial_mode && !path_r[avs_pkg::EN_BIT] |=> !fast_path_on)
    else $error("Path not in standby");
  a_sel_legal: assert property (
    fast_source_select != avs_pkg::SEL_ILLEGAL)
    else $error("Illegal source routed");
  a_sel_hold: assert property (
    cand_sel == avs_pkg::SEL_ILLEGAL |=> $stable(fast_source_select))
    else $error("Routing moved on illegal code");
  a_sb_off: assert property (
    serial_mode && !side_r[avs_pkg::EN_BIT] |=> !sideband_on)
    else $error("Sideband still conducting");
  a_sb_route: assert property (
    serial_mode && side_r[1:0] == 2'h1 ##1 side_r[1:0] == 2'h1
    |-> sideband_source_select == 2'h1)
    else $error("Sideband group B not routed");
  a_term_off: assert property (
    !cand_term |=> input_term_on_a == 4'h0 && input_term_on_c == 4'h0)
    else $error("Termination on while disabled");
  a_term_gap: assert property (
    sel_chg && cand_pulse[11] && cand_term && PULSE_CYC > 2
    |=> ##1 !input_term_on_c[0] [*2])
    else $error("Channel C0 termination not dropped");
  a_eq_map: assert property (
    $stable(cand_eq) |=> input_eq_high_c[3] == $past(cand_eq[8]) &&
      input_eq_high_a[0] == $past(cand_eq[4]))
    else $error("Equalizer bit mapped wrongly");
  a_preemph_all: assert property (
    $stable(cand_pe) |=> output_preemph_level == $past(cand_pe, 1))
    else $error("Pre-emphasis not applied");
  a_serial_keep: assert property (
    serial_mode |=> serial_mode)
    else $error("Serial mode dropped before reset");
endmodule

/* avs_host_model.sv */
// Serial host model that drives the switch control port
`timescale 1ns/1ps
module avs_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h55
) (
  // Clock
  input wire logic clk,
  // Serial port, data line is open drain with pull-up
  output logic scl,
  output logic sda_low,
  input wire logic sda_wire
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One serial phase, long enough for the device synchroniser
  task automatic tick();
    repeat (8) @(posedge clk);
    #2;
  endtask

  task automatic start();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      tick();
      scl = 1'b1;
      tick();
      scl = 1'b0;
      tick();
    end
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    ack = ~sda_wire;
    scl = 1'b0;
    tick();
  endtask

  // Last byte of a read is always refused by the host
  task automatic get_byte(output logic [7:0] b);
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tick();
      scl = 1'b1;
      tick();
      b[i] = sda_wire;
      scl = 1'b0;
    end
    tick();
    scl = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  task automatic probe(input logic [6:0] adr, output logic ack);
    start();
    put_byte({adr, 1'b0}, ack);
    stop();
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d,
                    output logic ack);
    logic a1;
    logic a2;
    logic a3;
    start();
    put_byte({DEV_ADDR, 1'b0}, a1);
    put_byte(p, a2);
    put_byte(d, a3);
    stop();
    ack = a1 & a2 & a3;
  endtask

  task automatic rd(input logic [7:0] p, output logic [7:0] d,
                    output logic ack);
    logic a1;
    logic a2;
    logic a3;
    start();
    put_byte({DEV_ADDR, 1'b0}, a1);
    put_byte(p, a2);
    start();
    put_byte({DEV_ADDR, 1'b1}, a3);
    get_byte(d);
    stop();
    ack = a1 & a2 & a3;
  endtask
endmodule

/* av_switch_config_regs_bench.sv */
// Testbench for the switch configuration register bank
`timescale 1ns/1ps
module av_switch_config_regs_bench;
  localparam int PULSE = 400;
  localparam logic [7:0] OFS [8] = '{8'h00, 8'h01, 8'h10, 8'h11,
    8'h12, 8'h13, 8'h14, 8'h20};
  localparam logic [7:0] RSV [8] = '{8'h40, 8'h40, 8'h01, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h03};
  localparam logic [7:0] CODES [6] = '{8'h01, 8'h41, 8'h42, 8'h43,
    8'h00, 8'h40};
  logic clk, sys_rst, scl, sda_low, sda_wire, sda_out, sda_oe;
  logic addr_lsb_pin, strap_fast_on, strap_eq_high, a;
  logic [1:0] strap_source, strap_preemph, prev, sel;
  logic serial_mode, fast_path_on, sideband_on, output_term_on;
  logic [1:0] fast_source_select, sideband_source_select;
  logic [1:0] output_preemph_level;
  logic [3:0] input_term_on_a, input_term_on_b, input_term_on_c;
  logic [3:0] input_eq_high_a, input_eq_high_b, input_eq_high_c;
  int err_count = 0;
  int compares = 0;

  assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

  avs_host_model host (.clk(clk), .scl(scl), .sda_low(sda_low),
    .sda_wire(sda_wire));

  avs_config_regs #(.PULSE_CYC(PULSE)) dut (.clk(clk), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_lsb_pin(addr_lsb_pin), .strap_fast_on(strap_fast_on),
    .strap_source(strap_source), .strap_eq_high(strap_eq_high),
    .strap_preemph(strap_preemph), .serial_mode(serial_mode),
    .fast_path_on(fast_path_on), .fast_source_select(fast_source_select),
    .sideband_on(sideband_on),
    .sideband_source_select(sideband_source_select),
    .input_term_on_a(input_term_on_a), .input_term_on_b(input_term_on_b),
    .input_term_on_c(input_term_on_c), .input_eq_high_a(input_eq_high_a),
    .input_eq_high_b(input_eq_high_b), .input_eq_high_c(input_eq_high_c),
    .output_preemph_level(output_preemph_level),
    .output_term_on(output_term_on));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ack;
    host.wr(p, d, ack);
    check({7'h0, ack}, 8'h01);
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
    logic ack;
    logic [7:0] v;
    host.rd(p, v, ack);
    check({7'h0, ack}, 8'h01);
    check(v, exp);
  endtask

  task automatic chk_term(input logic [7:0] ab, input logic [3:0] c);
    check({input_term_on_a, input_term_on_b}, ab);
    check({4'h0, input_term_on_c}, {4'h0, c});
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    addr_lsb_pin = 1'b1;
    strap_fast_on = 1'b1;
    strap_source = 2'h2;
    strap_eq_high = 1'b1;
    strap_preemph = 2'h1;
    repeat (16) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    repeat (10) @(posedge clk);
    #2;
    check({fast_path_on, serial_mode, 4'h0, fast_source_select}, 8'h82);
    check({sideband_on, 5'h0, sideband_source_select}, 8'h82);
    check({input_eq_high_a, input_eq_high_b}, 8'hFF);
    check({5'h0, output_term_on, output_preemph_level}, 8'h05);
    host.probe(7'h54, a);
    check({6'h0, a, serial_mode}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd_chk(OFS[i], RSV[i]);
    end
    strap_source = 2'h1;
    rd_chk(8'h05, 8'h00);
    check({fast_path_on, serial_mode, 4'h0, fast_source_select}, 8'hC0);
    check({5'h0, output_term_on, output_preemph_level}, 8'h04);
    check({input_eq_high_a, input_eq_high_b}, 8'h00);
    for (int r = 0; r < 2; r++) begin
      prev = 2'h0;
      for (int i = 0; i < 6; i++) begin
        wr(r[7:0], CODES[i]);
        if (CODES[i][1:0] != 2'h3) begin
          prev = CODES[i][1:0];
        end
        sel = r ? sideband_source_select : fast_source_select;
        a = r ? sideband_on : fast_path_on;
        check({5'h0, a, sel}, {5'h0, CODES[i][6], prev});
      end
    end
    wr(8'h00, 8'hFF);
    rd_chk(8'h00, 8'h43);
    check({6'h0, fast_source_select}, 8'h00);
    wr(8'h00, 8'h40);
    wr(8'h13, 8'hA5);
    wr(8'h14, 8'h03);
    check({input_eq_high_a, input_eq_high_b}, 8'hA5);
    check({4'h0, input_eq_high_c}, 8'h0C);
    wr(8'h11, 8'h1F);
    wr(8'h12, 8'h09);
    wr(8'h00, 8'h42);
    chk_term(8'hE0, 4'h6);
    repeat (PULSE) @(posedge clk);
    #2;
    chk_term(8'hFF, 4'hF);
    wr(8'h00, 8'h42);
    chk_term(8'hFF, 4'hF);
    wr(8'h00, 8'h43);
    chk_term(8'hFF, 4'hF);
    wr(8'h10, 8'h00);
    chk_term(8'h00, 4'h0);
    wr(8'h10, 8'h01);
    chk_term(8'hFF, 4'hF);
    for (int pe = 0; pe < 4; pe++) begin
      wr(8'h20, {4'h0, pe[1:0], 2'h2});
      check({5'h0, output_term_on, output_preemph_level},
            {5'h0, 1'b1, pe[1:0]});
    end
    wr(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h0F);
    wr(8'h20, 8'h00);
    check({7'h0, output_term_on}, 8'h00);
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    repeat (10) @(posedge clk);
    #2;
    check({fast_path_on, serial_mode, 4'h0, fast_source_select}, 8'h81);
    conclude();
  end
endmodule
